// *** fbmrt_host.sv ***
// Host controller driving an asynchronous NOR flash through its pins
// How it works
// - Host holds reset low at least 35 us when the flash is busy at a reset request; the start-up pulse is always the short one.
// - Host holds reset low at least 100 ns when the flash is idle.
// - Host waits recovery from later of ready pin or reset rising.
// - Host writes words singly and never issues a buffered program.
// - Host never asserts output and write strobes together.
`timescale 1ns/1ps
module fbmrt_host #(
   parameter int RESET_LOW_BUSY_CYC = fbmrt_pkg::RESET_LOW_BUSY_CYC,
   parameter int POST_RESET_CYC = fbmrt_pkg::POST_RESET_CYC,
   parameter int BUSY_TIMEOUT_US = fbmrt_pkg::BLOCK_PROG_MAX_MS * 1000
) (
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   input wire logic clk_en,
   // User request
   input wire logic req_valid,
   output logic req_ready,
   input wire fbmrt_pkg::fbmrt_req_t req,
   // User answer
   output logic rsp_valid,
   output logic [15:0] rsp_data,
   output logic busy_timeout,
   output logic op_aborted,
   // Flash pins
   output fbmrt_pkg::fbmrt_pins_t pins,
   input wire logic [15:0] dq_in,
   input wire logic ready_status_pin
);
   fbmrt_pkg::fbmrt_state_t state_reg, state_next;
   logic [15:0] rsp_data_reg;
   logic rsp_valid_reg;
   logic timeout_reg;
   logic aborted_reg;
   logic ready_q;
   logic recovered_reg;
   logic tmr_load;
   logic [fbmrt_pkg::CNT_W-1:0] tmr_count;
   logic tmr_done;
   logic [fbmrt_pkg::CNT_W-1:0] poll_cnt_reg;

   // Cycles from a figure in nanoseconds, rounded up, never below one
   function automatic logic [fbmrt_pkg::CNT_W-1:0] ns_cyc(input int ns);
      int c;
      c = (ns * fbmrt_pkg::CLK_MHZ + 999) / 1000;
      if (c < 1) begin
         c = 1;
      end
      return fbmrt_pkg::CNT_W'(c);
   endfunction

   fbmrt_timer #(.W(fbmrt_pkg::CNT_W)) u_timer (
      .clock(clock),
      .arst_n(arst_n),
      .clk_en(clk_en),
      .load(tmr_load),
      .count(tmr_count),
      .done(tmr_done)
   );

   // Ready pin taken as synchronous; registered once for edge use
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ready_q <= 1'b1;
      end else if (clk_en) begin
         ready_q <= ready_status_pin;
      end
   end

   // Next state and timer loads
   always_comb begin
      state_next = state_reg;
      tmr_load = 1'b0;
      tmr_count = '0;
      unique case (state_reg)
         fbmrt_pkg::FBM_IDLE: begin
            if (!recovered_reg) begin
               // Release starts a fresh pulse, so its length never rests on how long reset was held
               state_next = fbmrt_pkg::FBM_RST_LOW;
               tmr_load = 1'b1;
               tmr_count = ready_q ? ns_cyc(fbmrt_pkg::RESET_LOW_IDLE_NS)
                                   : fbmrt_pkg::CNT_W'(RESET_LOW_BUSY_CYC);
            end else if (req_valid) begin
               if (req.reset) begin
                  state_next = fbmrt_pkg::FBM_RST_LOW;
                  tmr_load = 1'b1;
                  // Busy flash needs the long pulse, idle one the short
                  tmr_count = ready_q ? ns_cyc(fbmrt_pkg::RESET_LOW_IDLE_NS)
                                      : fbmrt_pkg::CNT_W'(RESET_LOW_BUSY_CYC);
               end else if (req.write) begin
                  // Words go out singly, never as a buffered program, so no alignment duty arises
                  state_next = fbmrt_pkg::FBM_WR_LOW;
                  tmr_load = 1'b1;
                  tmr_count = ns_cyc(fbmrt_pkg::WRITE_PULSE_NS);
               end else if (req.poll) begin
                  state_next = fbmrt_pkg::FBM_POLL;
                  tmr_load = 1'b1;
                  tmr_count = ns_cyc(fbmrt_pkg::READ_ACCESS_NS);
               end else begin
                  state_next = fbmrt_pkg::FBM_RD_WAIT;
                  tmr_load = 1'b1;
                  tmr_count = ns_cyc(fbmrt_pkg::READ_ACCESS_NS);
               end
            end
         end
         fbmrt_pkg::FBM_WR_LOW: begin
            if (tmr_done) begin
               // Strobe rises here; address and data stay for the latch edge
               state_next = fbmrt_pkg::FBM_WR_HIGH;
               tmr_load = 1'b1;
               tmr_count = ns_cyc(fbmrt_pkg::WRITE_RECOVERY_NS + fbmrt_pkg::WRITE_HIGH_NS);
            end
         end
         fbmrt_pkg::FBM_WR_HIGH: begin
            if (tmr_done) begin
               state_next = fbmrt_pkg::FBM_IDLE;
            end
         end
         fbmrt_pkg::FBM_RD_WAIT: begin
            if (tmr_done) begin
               state_next = fbmrt_pkg::FBM_RD_DONE;
            end
         end
         fbmrt_pkg::FBM_RD_DONE: begin
            state_next = fbmrt_pkg::FBM_IDLE;
         end
         fbmrt_pkg::FBM_RST_LOW: begin
            if (tmr_done) begin
               // Wait covers internal reset plus recovery to valid output
               state_next = fbmrt_pkg::FBM_RST_REC;
               tmr_load = 1'b1;
               tmr_count = fbmrt_pkg::CNT_W'(POST_RESET_CYC);
            end
         end
         fbmrt_pkg::FBM_RST_REC: begin
            // Count restarts while ready stays low, so it runs from the later rise
            if (!ready_q) begin
               tmr_load = 1'b1;
               tmr_count = fbmrt_pkg::CNT_W'(POST_RESET_CYC);
            end else if (tmr_done) begin
               state_next = fbmrt_pkg::FBM_IDLE;
            end
         end
         fbmrt_pkg::FBM_POLL: begin
            if (tmr_done) begin
               state_next = fbmrt_pkg::FBM_RD_DONE;
            end
         end
         default: begin
            state_next = fbmrt_pkg::FBM_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= fbmrt_pkg::FBM_IDLE;
      end else if (clk_en) begin
         state_reg <= state_next;
      end
   end

   // Recovery flag: false until the first reset sequence completes
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         recovered_reg <= 1'b0;
      end else if (clk_en) begin
         if (state_reg == fbmrt_pkg::FBM_RST_REC && state_next == fbmrt_pkg::FBM_IDLE) begin
            recovered_reg <= 1'b1;
         end
      end
   end

   // Read data and answer pulse; busy status uses only bit 7
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rsp_data_reg <= '0;
         rsp_valid_reg <= 1'b0;
      end else if (clk_en) begin
         rsp_valid_reg <= 1'b0;
         if ((state_reg == fbmrt_pkg::FBM_RD_WAIT || state_reg == fbmrt_pkg::FBM_POLL) && tmr_done) begin
            rsp_valid_reg <= 1'b1;
            rsp_data_reg <= (state_reg == fbmrt_pkg::FBM_POLL) ? {8'h00, dq_in[7], 7'h00} : dq_in;
         end
      end
   end

   // Busy watchdog: flash runs algorithms alone, host only watches ready
   // Default bound is the longest worst case, covering
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         poll_cnt_reg <= '0;
         timeout_reg <= 1'b0;
      end else if (clk_en) begin
         if (ready_q || state_reg == fbmrt_pkg::FBM_RST_LOW) begin
            poll_cnt_reg <= '0;
         end else if (poll_cnt_reg < fbmrt_pkg::CNT_W'(BUSY_TIMEOUT_US * fbmrt_pkg::CLK_MHZ)) begin
            poll_cnt_reg <= poll_cnt_reg + 1'b1;
         end else begin
            timeout_reg <= 1'b1;
         end
         if (req_valid && req_ready && req.reset) begin
            timeout_reg <= 1'b0;
         end
      end
   end

   // Abort flag: reset while busy leaves target contents invalid
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         aborted_reg <= 1'b0;
      end else if (clk_en) begin
         if (req_valid && req_ready && req.reset) begin
            aborted_reg <= !ready_q;
         end
      end
   end

   // Pin drive; output and write strobes are never low together
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_power_down_n: 1'b0,
                   program_enable_supply: 1'b0, addr: '0, dq_out: '0, dq_oe: 1'b0};
      end else if (clk_en) begin
         pins.reset_power_down_n <= (state_next != fbmrt_pkg::FBM_RST_LOW);
         pins.program_enable_supply <= 1'b1;
         pins.we_n <= (state_next != fbmrt_pkg::FBM_WR_LOW);
         pins.oe_n <= !(state_next == fbmrt_pkg::FBM_RD_WAIT || state_next == fbmrt_pkg::FBM_POLL);
         pins.ce_n <= !(state_next == fbmrt_pkg::FBM_WR_LOW || state_next == fbmrt_pkg::FBM_RD_WAIT
                        || state_next == fbmrt_pkg::FBM_POLL);
         // Data bus driven only across the write, never while flash may drive it
         pins.dq_oe <= (state_next == fbmrt_pkg::FBM_WR_LOW || state_next == fbmrt_pkg::FBM_WR_HIGH);
         if (req_valid && req_ready) begin
            pins.addr <= req.addr;
            pins.dq_out <= req.data;
         end
      end
   end

   // Reads after reset need no command: flash is in array read
   assign req_ready = (state_reg == fbmrt_pkg::FBM_IDLE) && recovered_reg && clk_en; // A frozen cycle takes nothing
   assign rsp_valid = rsp_valid_reg;
   assign rsp_data = rsp_data_reg;
   assign busy_timeout = timeout_reg;
   assign op_aborted = aborted_reg;
endmodule // fbmrt_host

// *** fbmrt_pkg.sv ***
// Package: constants, states and carrier types for the flash bus host controller
package fbmrt_pkg;
   localparam int CLK_MHZ = 25;
   // Reset pulse minimums, recovery figures, write and read access times
   localparam int RESET_LOW_BUSY_US = 35;
   localparam int RESET_LOW_IDLE_NS = 100;
   localparam int RESET_DONE_NS = 100;
   localparam int RECOVERY_NS = 210;
   localparam int WRITE_PULSE_NS = 70;
   localparam int WRITE_HIGH_NS = 30;
   localparam int WRITE_RECOVERY_NS = 35;
   localparam int READ_ACCESS_NS = 150;
   localparam int POST_RESET_US = 1;
   // Cycle counts, least times rounded up
   localparam int RESET_LOW_BUSY_CYC = RESET_LOW_BUSY_US * CLK_MHZ;
   localparam int RESET_LOW_IDLE_CYC = (RESET_LOW_IDLE_NS * CLK_MHZ + 999) / 1000;
   localparam int RECOVERY_CYC = ((RESET_DONE_NS + RECOVERY_NS) * CLK_MHZ + 999) / 1000;
   localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int WRITE_HIGH_CYC = (WRITE_HIGH_NS * CLK_MHZ + 999) / 1000;
   localparam int WRITE_RECOVERY_CYC = (WRITE_RECOVERY_NS * CLK_MHZ + 999) / 1000;
   localparam int READ_ACCESS_CYC = (READ_ACCESS_NS * CLK_MHZ + 999) / 1000;
   localparam int POST_RESET_CYC = POST_RESET_US * CLK_MHZ;
   // Operation durations: worst and typical cases in microseconds or milliseconds, then buffer, command and width constants
   localparam int BUF_PROG_MAX_US = 654;
   localparam int WORD_PROG_MAX_US = 630;
   localparam int BLOCK_PROG_MAX_MS = 2400;
   localparam int CLEAR_LOCK_MAX_MS = 1400;
   localparam int PROG_SUSPEND_MAX_US = 90;
   localparam int ERASE_SUSPEND_MAX_US = 40;
   localparam int WORD_PROG_TYP_US = 210;
   localparam int BUF_PROG_TYP_US = 218;
   localparam int BUF_ALIGN_BYTES = 32;
   localparam logic [7:0] STATUS_READY = 8'h80;
   localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
   localparam int CNT_W = 32;

   // Host controller states
   typedef enum logic [7:0] {
      FBM_IDLE = 8'h01,
      FBM_WR_LOW = 8'h02,
      FBM_WR_HIGH = 8'h04,
      FBM_RD_WAIT = 8'h08,
      FBM_RD_DONE = 8'h10,
      FBM_RST_LOW = 8'h20,
      FBM_RST_REC = 8'h40,
      FBM_POLL = 8'h80
   } fbmrt_state_t;

   // Request from the user side
   typedef struct packed {
      logic write;
      logic reset;
      logic poll;
      logic [23:0] addr;
      logic [15:0] data;
   } fbmrt_req_t;

   // Pins towards the flash (outputs)
   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic reset_power_down_n;
      logic program_enable_supply;
      logic [23:0] addr;
      logic [15:0] dq_out;
      logic dq_oe;
   } fbmrt_pins_t;
endpackage : fbmrt_pkg

// *** fbmrt_timer.sv ***
// Down counter that measures pin timings and reset and recovery waits
`timescale 1ns/1ps
module fbmrt_timer #(
   parameter int W = 32
) (
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   input wire logic clk_en,
   // Control
   input wire logic load,
   input wire logic [W-1:0] count,
   // Status
   output logic done
);
   logic [W-1:0] cnt_reg;

   // Load wins over counting so a new interval always restarts cleanly
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg <= '0;
      end else if (clk_en) begin
         if (load) begin
            cnt_reg <= count;
         end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
         end
      end
   end

   // Done looks at the count alone: gating it with load would close a loop through the
   // controller's next-state logic, which itself loads on done
   assign done = (cnt_reg == '0);
endmodule // fbmrt_timer

// *** fbmrt_checker_sva.sv ***
// Checker: pin timing rules the flash host controller must keep
`timescale 1ns/1ps
module fbmrt_checker #(
   parameter int RESET_LOW_BUSY_CYC = 875,
   parameter int POST_RESET_CYC = 25
) (
   // Clock and reset
   input wire logic clock,
   input wire logic arst_n,
   input wire logic clk_en,
   // Flash side
   input wire fbmrt_pkg::fbmrt_pins_t pins,
   input wire logic ready_status_pin
);
   int low_cnt;
   int rec_cnt;
   logic busy_seen;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);
   // Reset pulse length; busy is taken while the pin is still high
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         low_cnt <= 0;
         busy_seen <= 1'b0;
      end else if (clk_en) begin
         low_cnt <= pins.reset_power_down_n ? 0 : low_cnt + 1;
         busy_seen <= pins.reset_power_down_n ? !ready_status_pin : busy_seen;
      end
   end
   // Cycles since the later of reset release and ready high, saturating
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rec_cnt <= 0;
      end else if (!pins.reset_power_down_n) begin
         rec_cnt <= 0;
      end else if (clk_en && rec_cnt < POST_RESET_CYC) begin
         rec_cnt <= ready_status_pin ? rec_cnt + 1 : 0;
      end
   end
   property p_strobes_apart;
      !(!pins.oe_n && !pins.we_n);
   endproperty
   a_strobes_apart: assert property (p_strobes_apart) else $error("strobes overlap");
   property p_no_fight;
      !pins.oe_n |-> !pins.dq_oe;
   endproperty
   a_no_fight: assert property (p_no_fight) else $error("host drives bus in read");
   property p_busy_low;
      $rose(pins.reset_power_down_n) && busy_seen |-> low_cnt >= RESET_LOW_BUSY_CYC;
   endproperty
   a_busy_low: assert property (p_busy_low) else $error("busy reset pulse short");
   property p_idle_low;
      $rose(pins.reset_power_down_n) |-> low_cnt >= fbmrt_pkg::RESET_LOW_IDLE_CYC;
   endproperty
   a_idle_low: assert property (p_idle_low) else $error("reset pulse short");
   property p_recovery;
      $fell(pins.oe_n) |-> rec_cnt >= POST_RESET_CYC;
   endproperty
   a_recovery: assert property (p_recovery) else $error("read before recovery");
   property p_write_ok;
      $fell(pins.we_n) |-> pins.program_enable_supply && pins.oe_n && !pins.ce_n ##2 pins.dq_oe;
   endproperty
   a_write_ok: assert property (p_write_ok) else $error("bad write cycle");
endmodule // fbmrt_checker

bind fbmrt_host fbmrt_checker #(
   .RESET_LOW_BUSY_CYC(RESET_LOW_BUSY_CYC),
   .POST_RESET_CYC(POST_RESET_CYC)
) fbmrt_checker_i (
   .clock(clock),
   .arst_n(arst_n),
   .clk_en(clk_en),
   .pins(pins),
   .ready_status_pin(ready_status_pin)
);

// *** fbmrt_flash_model.sv ***
// Behavioural flash device answering the host controller pins
`timescale 1ns/1ps
module fbmrt_flash_model (
   // Clock
   input wire logic clock,
   // Host pins and program length
   input wire fbmrt_pkg::fbmrt_pins_t pins,
   input wire logic [15:0] prog_cyc,
   // Device outputs
   output logic [15:0] dq_in,
   output logic ready_status_pin
);
   logic [15:0] mem [16];
   fbmrt_pkg::fbmrt_pins_t prv;
   logic [15:0] busy = 16'h0000;
   logic [15:0] noise = 16'hA5C3;
   logic [1:0] mode = 2'h0;
   logic [3:0] tgt;
   logic abrt = 1'b0;
   logic [15:0] rd;
   logic drive;
   initial begin
      for (int i = 0; i < 16; i++) begin
         mem[i] = {4{i[3:0]}};
      end
   end
   // Algorithm engine; commands latch on the write strobe rise
   always @(posedge clock) begin
      noise <= noise + 16'h3B5D;
      prv <= pins;
      if (!pins.reset_power_down_n) begin
         if (busy != 16'h0000) begin
            mem[tgt] <= ~mem[tgt];
         end
         abrt <= busy != 16'h0000 || abrt;
         busy <= 16'h0000;
         mode <= 2'h0;
      end else begin
         abrt <= 1'b0;
         if (busy != 16'h0000) begin
            busy <= busy - 16'h0001;
         end else if (!prv.we_n && pins.we_n && !prv.ce_n && prv.oe_n
                      && prv.program_enable_supply) begin
            if (mode == 2'h2) begin
               mem[prv.addr[3:0]] <= prv.dq_out;
               tgt <= prv.addr[3:0];
               busy <= prog_cyc; // Bench picks a length well inside the worst cases
               mode <= 2'h1;
            end else begin
               mode <= prv.dq_out[7:0] == 8'hFF ? 2'h0 : (prv.dq_out[7:0] == 8'h40 ? 2'h2 : 2'h1);
            end
         end
      end
   end
   // Undriven data lines wander so a stale value never passes
   assign drive = pins.reset_power_down_n && !pins.ce_n && !pins.oe_n && pins.we_n;
   // Status bit 7 stays readable as 0 all through busy; the other data lines carry noise
   assign rd = busy != 16'h0000 ? {noise[15:8], 1'b0, noise[6:0]}
               : (mode == 2'h0 ? mem[pins.addr[3:0]] : 16'h0080);
   assign dq_in = pins.dq_oe ? pins.dq_out : (drive ? rd : ~noise);
   assign ready_status_pin = busy == 16'h0000 && !abrt;
endmodule // fbmrt_flash_model

// *** tb_top.sv ***
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
module tb_top;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic clk_en = 1'b1;
   logic req_valid = 1'b0;
   logic req_ready;
   fbmrt_pkg::fbmrt_req_t req = '0;
   logic rsp_valid;
   logic [15:0] rsp_data;
   logic busy_timeout;
   logic op_aborted;
   fbmrt_pkg::fbmrt_pins_t pins;
   logic [15:0] dq_in;
   logic ready_status_pin;
   logic [15:0] prog_cyc = 16'h0028;
   logic [31:0] lfsr = 32'hE1B79066;
   logic [15:0] shadow [16];
   logic [15:0] exp_q [$];
   logic [3:0] a;
   int n_errors = 0;
   int tests_run = 0;
   int cycles = 0;

   always #20 clock = ~clock;

   fbmrt_host #(.RESET_LOW_BUSY_CYC(20), .POST_RESET_CYC(5), .BUSY_TIMEOUT_US(10)) fbmrt_host_i (
      .clock(clock), .arst_n(arst_n), .clk_en(clk_en), .req_valid(req_valid), .req_ready(req_ready),
      .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .busy_timeout(busy_timeout),
      .op_aborted(op_aborted), .pins(pins), .dq_in(dq_in), .ready_status_pin(ready_status_pin));
   fbmrt_flash_model fbmrt_flash_model_i (.clock(clock), .pins(pins), .prog_cyc(prog_cyc), .dq_in(dq_in),
      .ready_status_pin(ready_status_pin));

   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      if (n_errors == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic wait_ready();
      do @(negedge clock); while (req_ready !== 1'b1);
   endtask
   // One request; a random clock-enable stall follows the take
   task automatic send(input logic wr, input logic rs, input logic pl, input logic [3:0] ad, input logic [15:0] d);
      wait_ready();
      @(posedge clock);
      req_valid <= 1'b1;
      req <= {wr, rs, pl, 20'h00000, ad, d};
      wait_ready();
      @(posedge clock);
      lfsr = nxt(lfsr);
      req_valid <= 1'b0;
      clk_en <= lfsr[7];
      @(posedge clock);
      clk_en <= 1'b1;
   endtask
   task automatic rd(input logic [3:0] ad);
      exp_q.push_back(shadow[ad]);
      send(1'b0, 1'b0, 1'b0, ad, 16'h0000);
   endtask
   task automatic poll(input logic [15:0] e);
      exp_q.push_back(e);
      send(1'b0, 1'b0, 1'b1, 4'h0, 16'h0000);
   endtask
   task automatic prog(input logic [3:0] ad, input logic [15:0] d);
      send(1'b1, 1'b0, 1'b0, ad, 16'h0040);
      send(1'b1, 1'b0, 1'b0, ad, d);
   endtask

   // Result watcher: oldest note against each answer
   always @(negedge clock) begin
      if (rsp_valid === 1'b1) begin
         check(rsp_data, exp_q.size() > 0 ? exp_q.pop_front() : 16'hXXXX);
      end
   end
   // Hang guard, far above the expected run length
   always @(posedge clock) begin
      cycles++;
      if (cycles == 30000) begin
         n_errors++;
         finish_test();
      end
   end

   initial begin
      for (int i = 0; i < 16; i++) begin
         shadow[i] = {4{i[3:0]}};
      end
      repeat (8) @(posedge clock);
      arst_n <= 1'b1;
      rd(4'h3);
      send(1'b1, 1'b0, 1'b0, 4'h5, 16'h00FF);
      rd(4'h5);
      for (int i = 0; i < 3; i++) begin
         lfsr = nxt(lfsr);
         a = lfsr[19:16];
         shadow[a] = lfsr[15:0];
         prog(a, lfsr[15:0]);
         poll(16'h0000);
         do @(negedge clock); while (ready_status_pin !== 1'b1);
         poll(16'h0080);
         send(1'b1, 1'b0, 1'b0, a, 16'h00FF);
         rd(a);
      end
      // Reset in mid-program, then with the device idle
      prog(4'h9, 16'h1234);
      send(1'b0, 1'b1, 1'b0, 4'h0, 16'h0000);
      wait_ready();
      check({15'h0000, op_aborted}, 16'h0001);
      rd(4'h3);
      send(1'b0, 1'b1, 1'b0, 4'h0, 16'h0000);
      wait_ready();
      check({15'h0000, op_aborted}, 16'h0000);
      // Device stuck busy past the timeout, cleared by a reset
      @(posedge clock);
      prog_cyc <= 16'h0200;
      prog(4'h7, 16'h5A5A);
      repeat (300) @(posedge clock);
      check({15'h0000, busy_timeout}, 16'h0001);
      send(1'b0, 1'b1, 1'b0, 4'h0, 16'h0000);
      wait_ready();
      check({15'h0000, busy_timeout}, 16'h0000);
      @(posedge clock);
      arst_n <= 1'b0;
      repeat (3) @(posedge clock);
      arst_n <= 1'b1;
      rd(4'h3);
      wait_ready();
      check(16'(exp_q.size()), 16'h0000);
      finish_test();
   end
endmodule // tb_top
